// >>> rtl/iscb_ctrl.sv
`timescale 1ns/1ps
`include "iscb_params.svh"
module iscb_ctrl
  import iscb_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Decoded instruction from the fetch unit.
  input wire logic inst_valid,
  input wire logic [2:0] inst_class,
  input wire logic inst_is_call,
  input wire logic inst_cond_true,
  input wire logic inst_sets_cc,
  input wire logic [4:0] inst_src1,
  input wire logic [4:0] inst_src2,
  input wire logic inst_src1_lit,
  input wire logic inst_src2_lit,
  input wire logic [4:0] inst_dst,
  input wire logic inst_has_dst,
  input wire logic [1:0] inst_nregs,
  input wire logic [2:0] inst_ea_cycles,
  output logic inst_ready,
  // Branch outcome to the fetch unit.
  output logic fetch_redirect,
  // Dispatch strobes to execution resources.
  output logic int_issue,
  output logic mseq_issue,
  output logic bus_issue,
  output logic float_issue,
  output logic fault_raise,
  output logic bypass_hit,
  // Result write-backs.
  input wire logic reg_wr,
  input wire logic [4:0] reg_wr_addr,
  input wire logic [3:0] reg_wr_cnt,
  input wire logic cc_wr,
  // Frame memory traffic done flag.
  input wire logic frame_mem_done,
  output logic frame_spill,
  output logic frame_fill,
  output logic [1:0] cur_bank,
  output logic cc_busy,
  output logic [31:0] reg_busy
);

  // ****************************************************************
  // Scoreboards
  // ****************************************************************
  logic [31:0] reg_busy_r;
  logic cc_busy_r;
  logic [31:0] set_mask;
  logic [31:0] clr_mask;
  logic src_hazard;
  logic issue;
  logic [4:0] prev_dst_r;
  logic prev_valid_r;

  // Group mask for multi-register globals, single bit otherwise.
  function automatic logic [31:0] grp_mask(input logic [4:0] b, input logic [1:0] n);
    logic [31:0] m;
    m = 32'h0000_0001 << b;
    if (n != 2'h0 && !b[4]) begin
      case (b[3:1])
        3'h0, 3'h1: m = 32'h0000_000F;
        3'h2, 3'h3: m = 32'h0000_00FF;
        3'h4, 3'h5: m = 32'h0000_0F00;
        3'h6: m = 32'h0000_F000;
        default: m = 32'h0000_7000;
      endcase
    end
    return m;
  endfunction : grp_mask

  // Hazard: a non-literal source reads a busy register.
  // readers of busy stall
  assign src_hazard = (!inst_src1_lit && reg_busy_r[inst_src1])
                    || (!inst_src2_lit && reg_busy_r[inst_src2]);

  // Destination mask; single register flags only itself.
  // Only loads leave a result outstanding; one-cycle ALU results are forwarded.
  // register group for multi-register loads
  assign set_mask = (bus_issue && inst_has_dst) ? grp_mask(inst_dst, inst_nregs) : 32'h0;
  assign clr_mask = reg_wr ? grp_mask(reg_wr_addr, reg_wr_cnt[1:0]) : 32'h0;

  // Register scoreboard update; a new set wins over a clear.
  // load busy until written
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reg_busy_r <= 32'h0;
    end else begin
      reg_busy_r <= (reg_busy_r & ~clr_mask) | set_mask;
    end
  end

  // Condition-code scoreboard: set by producer, cleared on write.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cc_busy_r <= 1'b0;
    end else if (issue && inst_sets_cc) begin
      cc_busy_r <= 1'b1;
    end else if (cc_wr) begin
      cc_busy_r <= 1'b0;
    end
  end

  // Previous destination for forwarding.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prev_dst_r <= 5'h00;
      prev_valid_r <= 1'b0;
    end else if (issue) begin
      prev_dst_r <= inst_dst;
      prev_valid_r <= inst_has_dst && inst_class == `ISCB_CLS_SIMPLE;
    end
  end

  // ****************************************************************
  // Bypass and execution timing
  // ****************************************************************
  logic [1:0] exec_cnt_r;
  logic [2:0] ea_cnt_r;
  logic exec_busy;

  assign bypass_hit = inst_src1_lit || inst_src2_lit
                    || (prev_valid_r && inst_src2 == prev_dst_r);

  // Extra cycle for a miss and effective-address wait.
  // hit saves one cycle
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      exec_cnt_r <= 2'h0;
      ea_cnt_r <= 3'h0;
    end else if (issue) begin
      exec_cnt_r <= (inst_class == `ISCB_CLS_SIMPLE && !bypass_hit) ? 2'h1 : 2'h0;
      ea_cnt_r <= (inst_class == `ISCB_CLS_MEM && inst_ea_cycles <= `ISCB_EA_MAX)
                  ? inst_ea_cycles : 3'h0;
    end else begin
      if (exec_cnt_r != 2'h0) exec_cnt_r <= exec_cnt_r - 2'h1;
      if (ea_cnt_r != 3'h0) ea_cnt_r <= ea_cnt_r - 3'h1;
    end
  end

  // ****************************************************************
  // Frame allocation
  // ****************************************************************
  iscb_frame_type fstate_r;
  logic [2:0] depth_r;
  logic [2:0] spilled_r;
  logic [1:0] bank_r;
  logic [3:0] fcnt_r;
  logic call_go;
  logic ret_go;
  logic frame_idle;

  assign frame_idle = fstate_r == ISCB_IDLE;
  assign call_go = issue && inst_class == `ISCB_CLS_CALLRET && inst_is_call;
  assign ret_go = issue && inst_class == `ISCB_CLS_CALLRET && !inst_is_call;

  // Call/return sequencer with spill and refill phases.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fstate_r <= ISCB_IDLE;
      depth_r <= 3'h0;
      spilled_r <= 3'h0;
      bank_r <= 2'h0;
      fcnt_r <= 4'h0;
    end else begin
      case (fstate_r)
        ISCB_IDLE: begin
          if (call_go) begin
            bank_r <= bank_r + 2'h1;
            if (depth_r == 3'(`ISCB_NUM_BANKS - 1)) begin
              spilled_r <= spilled_r + 3'h1;
              fstate_r <= ISCB_SPILL;
            end else begin
              depth_r <= depth_r + 3'h1;
              fstate_r <= ISCB_BUSY;
            end
            fcnt_r <= `ISCB_CALL_CYC - 4'h1;
          end else if (ret_go) begin
            bank_r <= bank_r - 2'h1;
            fcnt_r <= `ISCB_RET_CYC - 4'h1;
            if (depth_r == 3'h0 && spilled_r != 3'h0) begin
              spilled_r <= spilled_r - 3'h1;
              fstate_r <= ISCB_FILL;
            end else begin
              if (depth_r != 3'h0) depth_r <= depth_r - 3'h1;
              fstate_r <= ISCB_BUSY;
            end
          end
        end
        ISCB_SPILL, ISCB_FILL: begin
          if (frame_mem_done) fstate_r <= ISCB_BUSY;
        end
        ISCB_BUSY: begin
          if (fcnt_r <= 4'h1) fstate_r <= ISCB_IDLE;
          fcnt_r <= fcnt_r - 4'h1;
        end
        default: fstate_r <= ISCB_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Decode and dispatch
  // ****************************************************************
  // Stall on operand hazard, pending condition code, busy units.
  // branch waits on code
  always_comb begin
    inst_ready = frame_idle && exec_cnt_r == 2'h0 && ea_cnt_r == 3'h0 && !src_hazard;
    if ((inst_class == `ISCB_CLS_CBRANCH || inst_class == `ISCB_CLS_CFAULT) && cc_busy_r)
      inst_ready = 1'b0;
  end
  assign issue = inst_valid && inst_ready;

  // Routing; branches stay in the decoder, no unit strobe.
  // decoder executes branches
  assign fetch_redirect = issue && (inst_class == `ISCB_CLS_BRANCH
                        || (inst_class == `ISCB_CLS_CBRANCH && inst_cond_true));
  assign fault_raise = issue && inst_class == `ISCB_CLS_CFAULT && inst_cond_true;
  assign int_issue = issue && inst_class == `ISCB_CLS_SIMPLE;
  assign mseq_issue = issue && (inst_class == `ISCB_CLS_COMPLEX || fault_raise);
  assign bus_issue = issue && inst_class == `ISCB_CLS_MEM;
  assign float_issue = issue && inst_class == `ISCB_CLS_FLOAT;

  // Status outputs; register file banks are selected by cur_bank.
  // four local banks
  assign cur_bank = bank_r;
  assign frame_spill = fstate_r == ISCB_SPILL;
  assign frame_fill = fstate_r == ISCB_FILL;
  assign cc_busy = cc_busy_r;
  assign reg_busy = reg_busy_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  a_cc_branch_stall: assert property (cc_busy && inst_class == `ISCB_CLS_CBRANCH |-> !issue)
    else $error("branch issued with pending code");
  a_cc_mark_set: assert property (issue && inst_sets_cc |=> cc_busy)
    else $error("code not marked pending");
  a_reg_busy_stall: assert property (!inst_src1_lit && reg_busy[inst_src1] |-> !issue)
    else $error("busy register read");
  a_load_dst_busy: assert property (bus_issue && inst_has_dst && inst_nregs == 2'h0
    && !(reg_wr && reg_wr_addr == inst_dst) |=> reg_busy[$past(inst_dst)])
    else $error("load destination not busy");
  a_clear_on_write: assert property (reg_wr && reg_wr_cnt == 4'h0 && !set_mask[reg_wr_addr]
    |=> !reg_busy[$past(reg_wr_addr)])
    else $error("flag not cleared");
  a_lit_bypass: assert property (inst_src2_lit |-> bypass_hit)
    else $error("literal missed bypass");
  a_miss_cost: assert property (int_issue && !bypass_hit |=> !inst_ready ##1 exec_cnt_r == 2'h0)
    else $error("miss timing wrong");
  a_call_nine: assert property (call_go && depth_r < 3'h3 |=> !frame_idle [*8] ##1 frame_idle)
    else $error("call length wrong");
  a_redirect_now: assert property (issue && inst_class == `ISCB_CLS_BRANCH |-> fetch_redirect
    && !int_issue && !bus_issue)
    else $error("branch not redirected");

  c_spill: cover property (frame_spill);
  c_fill: cover property (frame_fill);
  c_cc_stall: cover property (cc_busy && inst_valid && inst_class == `ISCB_CLS_CBRANCH);
  c_fault: cover property (fault_raise);

endmodule : iscb_ctrl

// >>> rtl/iscb_params.svh
`ifndef ISCB_PARAMS_SVH
`define ISCB_PARAMS_SVH
// Instruction class codes presented by the fetch side.
`define ISCB_CLS_SIMPLE 3'h0
`define ISCB_CLS_BRANCH 3'h1
`define ISCB_CLS_CBRANCH 3'h2
`define ISCB_CLS_CFAULT 3'h3
`define ISCB_CLS_COMPLEX 3'h4
`define ISCB_CLS_MEM 3'h5
`define ISCB_CLS_FLOAT 3'h6
`define ISCB_CLS_CALLRET 3'h7
// Short literal range.
`define ISCB_LIT_MIN (-16)
`define ISCB_LIT_MAX 31
// Local frame banks and call/return cycle counts.
`define ISCB_NUM_BANKS 4
`define ISCB_CALL_CYC 4'h9
`define ISCB_RET_CYC 4'h7
`define ISCB_EA_MAX 3'h4
`define ISCB_NUM_REGS 32
`endif

// >>> rtl/iscb_pkg.sv
package iscb_pkg;
  typedef enum logic [1:0] {
    ISCB_IDLE = 2'h0,
    ISCB_BUSY = 2'h1,
    ISCB_SPILL = 2'h3,
    ISCB_FILL = 2'h2
  } iscb_frame_type;
endpackage : iscb_pkg

// >>> verification/iscb_far_model.sv
`timescale 1ns/1ps
module iscb_far_model
  import iscb_pkg::*;
(
  // Clock, reset and reply delay.
  input wire logic mclk,
  input wire logic reset,
  input wire logic [3:0] lat,
  // Core side.
  input wire logic bus_issue,
  input wire logic int_issue,
  input wire logic inst_sets_cc,
  input wire logic inst_has_dst,
  input wire logic [4:0] inst_dst,
  input wire logic [1:0] inst_nregs,
  input wire logic frame_spill,
  input wire logic frame_fill,
  // Write-backs.
  output logic reg_wr,
  output logic [4:0] reg_wr_addr,
  output logic [3:0] reg_wr_cnt,
  output logic cc_wr,
  output logic frame_mem_done
);
  int ld_n = 0;
  int cc_n = 0;
  int fm_n = 0;
  logic [4:0] ld_a = 5'h00;
  logic [1:0] ld_g = 2'h0;
  // Requests are taken mid-cycle, where the strobes have settled.
  always @(negedge mclk) begin
    if (bus_issue && inst_has_dst) begin
      ld_n = int'(lat);
      ld_a = inst_dst;
      ld_g = inst_nregs;
    end
    if (int_issue && inst_sets_cc) cc_n = int'(lat);
  end
  // Outputs start low.
  initial {reg_wr, reg_wr_addr, reg_wr_cnt, cc_wr, frame_mem_done} = '0;
  // Replies come after the delay; idle address lines toggle every cycle.
  always @(posedge mclk) begin
    #1;
    if (reset) begin
      ld_n = 0;
      cc_n = 0;
      fm_n = 0;
    end
    if ((frame_spill || frame_fill) && fm_n == 0) fm_n = int'(lat) + 1;
    reg_wr = (ld_n == 1);
    cc_wr = (cc_n == 1);
    frame_mem_done = (fm_n == 1);
    if (reg_wr) begin
      reg_wr_addr = ld_a;
      reg_wr_cnt = {2'h0, ld_g};
    end else begin
      reg_wr_addr = ~reg_wr_addr;
      reg_wr_cnt = ~reg_wr_cnt;
    end
    if (ld_n > 0) ld_n--;
    if (cc_n > 0) cc_n--;
    if (fm_n > 0) fm_n--;
  end
endmodule : iscb_far_model

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`include "iscb_params.svh"
module tb_top
  import iscb_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic inst_valid, inst_is_call, inst_cond_true, inst_sets_cc, inst_src1_lit, inst_src2_lit;
  logic inst_has_dst, reg_wr, cc_wr, frame_mem_done, inst_ready, fetch_redirect, int_issue;
  logic mseq_issue, bus_issue, float_issue, fault_raise, bypass_hit, frame_spill, frame_fill;
  logic cc_busy, psimp, spill_seen, fill_seen;
  logic [1:0] inst_nregs, cur_bank;
  logic [2:0] inst_class, inst_ea_cycles;
  logic [3:0] reg_wr_cnt, lat;
  logic [4:0] inst_src1, inst_src2, inst_dst, reg_wr_addr, pdst, r;
  logic [31:0] reg_busy, m;
  int errors = 0;
  int n_compared = 0;
  int seed = 84;
  int w = 0;
  int pw = 0;
  logic [6:0] seen_s;
  typedef struct {logic [6:0] exp; logic [6:0] msk; int ew;} iscb_note_type;
  iscb_note_type notes[$];
  iscb_note_type nt;
  iscb_ctrl i_dut (.mclk, .reset, .inst_valid, .inst_class, .inst_is_call, .inst_cond_true,
    .inst_sets_cc, .inst_src1, .inst_src2, .inst_src1_lit, .inst_src2_lit, .inst_dst,
    .inst_has_dst, .inst_nregs, .inst_ea_cycles, .inst_ready, .fetch_redirect, .int_issue,
    .mseq_issue, .bus_issue, .float_issue, .fault_raise, .bypass_hit, .reg_wr, .reg_wr_addr,
    .reg_wr_cnt, .cc_wr, .frame_mem_done, .frame_spill, .frame_fill, .cur_bank, .cc_busy,
    .reg_busy);
  iscb_far_model i_far (.mclk, .reset, .lat, .bus_issue, .int_issue, .inst_sets_cc,
    .inst_has_dst, .inst_dst, .inst_nregs, .frame_spill, .frame_fill, .reg_wr, .reg_wr_addr,
    .reg_wr_cnt, .cc_wr, .frame_mem_done);
  // Clock.
  always #10 mclk = ~mclk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Offers one instruction, f = {call, cond, sets_cc, lit1, lit2, has_dst}; ew < 0 is a minimum.
  task automatic iss(input logic [2:0] c, input logic [5:0] f, input logic [4:0] s1, s2, d,
      input logic [1:0] nr, input logic [2:0] ea, input int ew);
    iscb_note_type n;
    logic hit;
    int k;
    hit = f[2] | f[1] | (psimp && s2 == pdst);
    n.msk = (c == 3'h7) ? 7'h00 : (c == 3'h0) ? 7'h7F : 7'h7E;
    case (c)
      3'h0: n.exp = {6'h10, hit};
      3'h1: n.exp = 7'h40;
      3'h2: n.exp = {f[4], 6'h00};
      3'h3: n.exp = {2'h0, f[4], 2'h0, f[4], 1'b0};
      3'h4: n.exp = 7'h10;
      3'h5: n.exp = 7'h08;
      default: n.exp = 7'h04;
    endcase
    // A miss or an address wait stalls the next offer, not this one.
    n.ew = (ew >= 0) ? ew + pw : ew;
    pw = (c == 3'h0 && !hit) ? 1 : (c == 3'h5 && ea <= 3'h4) ? int'(ea) : 0;
    notes.push_back(n);
    psimp = (c == 3'h0) && f[0];
    pdst = d;
    {inst_class, inst_is_call, inst_cond_true, inst_sets_cc, inst_src1_lit} = {c, f[5:2]};
    {inst_src2_lit, inst_has_dst, inst_src1, inst_src2, inst_dst} = {f[1:0], s1, s2, d};
    {inst_nregs, inst_ea_cycles, inst_valid} = {nr, ea, 1'b1};
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (inst_ready !== 1'b1 && k < 40);
    if (k == 40) chk("issue", 32'h1, 32'h0);
    @(posedge mclk);
    #1;
  endtask : iss
  task automatic idle(input int n);
    pw = (pw > n) ? pw - n : 0;
    inst_valid = 1'b0;
    repeat (n) @(posedge mclk);
    #1;
  endtask : idle
  task automatic wrap_up;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // Each offer is seen mid-cycle: it waits, or it issues and its note is compared.
  always @(negedge mclk) begin
    if (frame_spill === 1'b1) spill_seen = 1'b1;
    if (frame_fill === 1'b1) fill_seen = 1'b1;
    if (inst_valid && inst_ready !== 1'b1) w++;
    else if (inst_valid && notes.size() > 0) begin
      nt = notes.pop_front();
      seen_s = {fetch_redirect, int_issue, mseq_issue, bus_issue, float_issue, fault_raise,
        bypass_hit};
      chk("strobes", 32'(nt.exp & nt.msk), 32'(seen_s & nt.msk));
      if (nt.ew >= 0) chk("wait", nt.ew, w);
      else chk("wait_min", 32'h1, 32'(w >= -nt.ew));
      w = 0;
    end
  end
  // Watchdog.
  initial begin
    #200000;
    errors++;
    wrap_up();
  end
  // Main sequence.
  initial begin
    int cw;
    int rw;
    cw = int'(`ISCB_CALL_CYC) - 1;
    rw = int'(`ISCB_RET_CYC) - 1;
    {inst_valid, inst_class, inst_is_call, inst_cond_true, inst_sets_cc, inst_src1} = '0;
    {inst_src2, inst_src1_lit, inst_src2_lit, inst_dst, inst_has_dst, inst_nregs} = '0;
    {inst_ea_cycles, psimp, pdst, spill_seen, fill_seen} = '0;
    lat = 4'h2;
    repeat (16) @(posedge mclk);
    #1;
    reset = 1'b0;
    chk("idle", 32'h0, {reg_busy[29:0], cc_busy, frame_spill | frame_fill});
    for (int c = 0; c < 7; c++) begin
      for (int b = 0; b < 2; b++) iss(3'(c), {1'b0, 1'(b), 4'h4}, 5'($random(seed)),
        5'($random(seed)), 5'h02, 2'h0, 3'h0, 0);
    end
    iss(3'h0, 6'h01, 5'h10, 5'h11, 5'h05, 2'h0, 3'h0, 0);
    iss(3'h0, 6'h01, 5'h12, 5'h05, 5'h06, 2'h0, 3'h0, 0);
    iss(3'h0, 6'h02, 5'h13, 5'h1F, 5'h07, 2'h0, 3'h0, 0);
    for (int k = 0; k < 6; k++) iss(3'h5, 6'h00, 5'h01, 5'h02, 5'h03, 2'h0, 3'(k), 0);
    lat = 4'h6;
    r = 5'($random(seed));
    iss(3'h5, 6'h01, r ^ 5'h1F, r ^ 5'h1E, r, 2'h0, 3'h0, 0);
    chk("reg_busy", 32'h1 << r, reg_busy);
    iss(3'h0, 6'h02, r ^ 5'h01, r ^ 5'h02, 5'h00, 2'h0, 3'h0, 0);
    iss(3'h0, 6'h02, r, r ^ 5'h02, 5'h00, 2'h0, 3'h0, -1);
    chk("reg_busy", 32'h0, reg_busy);
    lat = 4'h2;
    for (int b = 0; b < 16; b += 2) begin
      idle(6);
      m = (b < 4) ? 32'h000F : (b < 8) ? 32'h00FF : (b < 12) ? 32'h0F00 : 32'hF000;
      if (b == 14) m = 32'h7000;
      iss(3'h5, 6'h01, 5'h10, 5'h11, 5'(b), 2'h1, 3'h0, 0);
      chk("group", m, reg_busy);
    end
    lat = 4'h3;
    idle(6);
    iss(3'h0, 6'h0C, 5'h01, 5'h02, 5'h03, 2'h0, 3'h0, 0);
    chk("cc_busy", 32'h1, 32'(cc_busy));
    iss(3'h0, 6'h04, 5'h04, 5'h05, 5'h06, 2'h0, 3'h0, 0);
    iss(3'h2, 6'h10, 5'h04, 5'h05, 5'h06, 2'h0, 3'h0, -1);
    chk("cc_busy", 32'h0, 32'(cc_busy));
    lat = 4'h4;
    idle(2);
    for (int k = 0; k < 5; k++) iss(3'h7, 6'h24, 5'h01, 5'h02, 5'h03, 2'h0, 3'h0,
      (k == 0) ? 0 : (k < 4) ? cw : -cw);
    idle(30);
    chk("bank", 32'(5 % `ISCB_NUM_BANKS), 32'(cur_bank));
    chk("spill", 32'h1, 32'(spill_seen));
    for (int k = 0; k < 5; k++) iss(3'h7, 6'h04, 5'h01, 5'h02, 5'h03, 2'h0, 3'h0,
      (k == 0) ? 0 : (k < 3) ? rw : -rw);
    idle(30);
    chk("bank", 32'h0, 32'(cur_bank));
    chk("fill", 32'h1, 32'(fill_seen));
    wrap_up();
  end
endmodule : tb_top
